// File: core/sfad_dev_end.sv
/*
  Flash device end: instruction decoder and address-width selection.
  The frame logic runs on the link clock and is cleared while chip select
  is high; decoded commands are handed to the MCLK side by a toggle.
  Each decoded command is reported once, as a one-cycle pulse on MCLK with
  its opcode, class, address and address width held until the next one.
  Assumes the host keeps the link clock low outside frames (mode 0), and
  that straps change only while no frame is running.
*/
// How it works
// - Wide read opcodes always take four address bytes
// - Wide program, erase, ECC, protection take four bytes
// - Bit 7 of volatile_config_two picks legacy width
// - Bit one means four bytes, zero three
// - Reset reloads that bit from nonvolatile copy
// - Legacy reads follow the address-length bit
// - Other legacy opcodes follow the same bit
// - Identification read has no address bytes
// - Parameter table read uses fixed three bytes
// - Status and config reads, two refused quad-wide
// - Register write, write disable/enable, no address
// - 30 clears failure flags or means resume
// - 82 is alternate status clear, no address
// - B7 enters four-byte mode, refused quad-wide
// - Address arrives most significant byte first
// - Host drops quad-wide refusals; unknown opcodes still go out
`include "sfad_defs.svh"

module sfad_dev_end (
  // System clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Link
  sfad_link_if.dev_end LINK,
  // Configuration straps and controls
  input wire logic NV_ADDR_LEN,
  input wire logic QUAD_MODE,
  input wire logic RESUME_ON_30,
  input wire logic SW_RESET,
  // Decoded command
  output logic CMD_VALID,
  output logic [7:0] CMD_OPCODE,
  output sfad_pkg::sfad_cls_t CMD_CLASS,
  output logic [31:0] CMD_ADDR,
  output logic CMD_ADDR4,
  // Status
  output logic ADDR_LEN_4B
);
  sfad_pkg::sfad_frame_t f_r;
  sfad_pkg::sfad_frame_t f_nxt;
  sfad_pkg::sfad_link_t l_r;
  sfad_pkg::sfad_link_t l_nxt;
  sfad_pkg::sfad_sys_t s_r;
  sfad_pkg::sfad_sys_t s_nxt;
  logic frame_rst_n;
  logic ev_edge;

  // One serial bit into the frame shifter, most significant first
  function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic bit_in);
    return {sh[30:0], bit_in};
  endfunction

  // Chip select high ends any frame, even mid-byte, with no clock edge
  assign frame_rst_n = RST_N & ~LINK.cs_n;

  always_comb begin
    sfad_pkg::sfad_cmd_t dc;
    logic eff4;
    logic issue;
    dc = '{known: 1'b0, ak: sfad_pkg::AK_NONE, cls: sfad_pkg::CL_NONE};
    eff4 = 1'b0;
    issue = 1'b0;
    f_nxt = f_r;
    l_nxt = l_r;
    l_nxt.nv_s1 = NV_ADDR_LEN;
    l_nxt.nv_s2 = l_r.nv_s1;
    l_nxt.qd_s1 = QUAD_MODE;
    l_nxt.qd_s2 = l_r.qd_s1;
    l_nxt.rs_s1 = RESUME_ON_30;
    l_nxt.rs_s2 = l_r.rs_s1;
    l_nxt.sw_s1 = s_r.sw_tog;
    l_nxt.sw_s2 = l_r.sw_s1;
    // A pending reload uses the strap in place of the stored bit
    eff4 = l_r.load ? l_r.nv_s2 : l_r.cfg2[`SFAD_ALEN_BIT];
    unique case (f_r.ph)
      sfad_pkg::PH_INSTR: begin
        f_nxt.sh = shift_in(f_r.sh, LINK.si);
        f_nxt.cnt = f_r.cnt + 6'h01;
        if (f_r.cnt == `SFAD_INSTR_LAST) begin
          dc = sfad_pkg::sfad_decode(f_nxt.sh[7:0], l_r.qd_s2, l_r.rs_s2);
          f_nxt.op = f_nxt.sh[7:0];
          f_nxt.cls = dc.cls;
          f_nxt.cnt = 6'h00;
          if (l_r.load) begin
            l_nxt.cfg2[`SFAD_ALEN_BIT] = l_r.nv_s2;
            l_nxt.load = 1'b0;
          end
          if (!dc.known) begin
            // Quad-wide refusals land here as well
            f_nxt.ph = sfad_pkg::PH_DONE;
          end else if (dc.ak == sfad_pkg::AK_NONE) begin
            f_nxt.ph = sfad_pkg::PH_DONE;
            f_nxt.a4 = 1'b0;
            issue = 1'b1;
            if (dc.cls == sfad_pkg::CL_ENTER4B) begin
              l_nxt.cfg2[`SFAD_ALEN_BIT] = 1'b1;
            end
          end else begin
            // Fixed widths ignore the address-length bit
            f_nxt.a4 = (dc.ak == sfad_pkg::AK_FOUR) ||
                       ((dc.ak == sfad_pkg::AK_LEGACY) && eff4);
            f_nxt.last = f_nxt.a4 ? `SFAD_A4_LAST : `SFAD_A3_LAST;
            f_nxt.ph = sfad_pkg::PH_ADDR;
          end
        end
      end
      sfad_pkg::PH_ADDR: begin
        f_nxt.sh = shift_in(f_r.sh, LINK.si);
        f_nxt.cnt = f_r.cnt + 6'h01;
        if (f_r.cnt == f_r.last) begin
          f_nxt.ph = sfad_pkg::PH_DONE;
          issue = 1'b1;
        end
      end
      sfad_pkg::PH_DONE: begin
        f_nxt = f_r;
      end
      default: begin
        f_nxt.ph = sfad_pkg::PH_DONE;
      end
    endcase
    // A software reset seen on the same edge re-arms the reload
    if (l_r.sw_s2 != l_r.sw_seen) begin
      l_nxt.sw_seen = l_r.sw_s2;
      l_nxt.load = 1'b1;
    end
    if (issue) begin
      l_nxt.ev_tog = ~l_r.ev_tog;
      l_nxt.h_op = f_nxt.op;
      l_nxt.h_cls = f_nxt.cls;
      l_nxt.h_a4 = f_nxt.a4;
      if (f_nxt.ph != f_r.ph && f_r.ph == sfad_pkg::PH_INSTR) begin
        l_nxt.h_addr = 32'h0000_0000;
      end else if (f_nxt.a4) begin
        l_nxt.h_addr = f_nxt.sh;
      end else begin
        l_nxt.h_addr = {8'h00, f_nxt.sh[23:0]};
      end
    end
  end

  // Chip select is the frame's reset, so a cut frame leaves nothing behind
  always_ff @(posedge LINK.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f_r <= '{ph: sfad_pkg::PH_INSTR, cls: sfad_pkg::CL_NONE, default: '0};
    end else begin
      f_r <= f_nxt;
    end
  end

  // Configuration and hand-over words outlive chip select; only RST_N clears them
  always_ff @(posedge LINK.sck or negedge RST_N) begin
    if (!RST_N) begin
      l_r <= sfad_pkg::LINK_RST;
    end else begin
      l_r <= l_nxt;
    end
  end

  // A change on the synchronised toggle marks one new command
  assign ev_edge = s_r.ev_s2 ^ s_r.ev_s3;

  // Held command words are stable for many MCLK cycles after the toggle
  always_comb begin
    s_nxt = s_r;
    s_nxt.sw_tog = s_r.sw_tog ^ SW_RESET;
    s_nxt.ev_s1 = l_r.ev_tog;
    s_nxt.ev_s2 = s_r.ev_s1;
    s_nxt.ev_s3 = s_r.ev_s2;
    s_nxt.al_s1 = l_r.cfg2[`SFAD_ALEN_BIT];
    s_nxt.al_s2 = s_r.al_s1;
    s_nxt.valid = ev_edge;
    if (ev_edge) begin
      s_nxt.op = l_r.h_op;
      s_nxt.cls = l_r.h_cls;
      s_nxt.addr = l_r.h_addr;
      s_nxt.a4 = l_r.h_a4;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '{cls: sfad_pkg::CL_NONE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign CMD_VALID = s_r.valid;
  assign CMD_OPCODE = s_r.op;
  assign CMD_CLASS = s_r.cls;
  assign CMD_ADDR = s_r.addr;
  assign CMD_ADDR4 = s_r.a4;
  // The reload runs on the link clock, so this shows the strap only after
  // the first frame that follows a reset; until then it reads zero after RST_N, or the old bit after SW_RESET
  assign ADDR_LEN_4B = s_r.al_s2;
endmodule // sfad_dev_end

// File: core/sfad_defs.svh
/*
  Opcodes, field positions, bit counts and rates for the serial flash
  address-width command decoder.
  Assumes inclusion by the package and by both link ends; the guard keeps
  a second inclusion harmless. Holds definitions alone.
*/
`ifndef SFAD_DEFS_SVH
`define SFAD_DEFS_SVH
`define SFAD_OP_WIDE_READ 8'h13
`define SFAD_OP_WIDE_FAST_READ 8'h0C
`define SFAD_OP_WIDE_DUAL_IO 8'hBC
`define SFAD_OP_WIDE_QUAD_IO 8'hEC
`define SFAD_OP_WIDE_DDR_QUAD 8'hEE
`define SFAD_OP_WIDE_PROGRAM 8'h12
`define SFAD_OP_WIDE_PARAM_ERASE 8'h21
`define SFAD_OP_WIDE_SECTOR_ERASE 8'hDC
`define SFAD_OP_WIDE_ECC_READ 8'h18
`define SFAD_OP_WIDE_PROT_FIRST 8'hE0
`define SFAD_OP_WIDE_PROT_LAST 8'hE3
`define SFAD_OP_READ 8'h03
`define SFAD_OP_FAST_READ 8'h0B
`define SFAD_OP_DUAL_IO 8'hBB
`define SFAD_OP_QUAD_IO 8'hEB
`define SFAD_OP_DDR_QUAD 8'hED
`define SFAD_OP_PROGRAM 8'h02
`define SFAD_OP_PARAM_ERASE 8'h20
`define SFAD_OP_SECTOR_ERASE 8'hD8
`define SFAD_OP_ANY_REG_READ 8'h65
`define SFAD_OP_ANY_REG_WRITE 8'h71
`define SFAD_OP_ERASE_EVAL 8'hD0
`define SFAD_OP_OTP_PROGRAM 8'h42
`define SFAD_OP_OTP_READ 8'h4B
`define SFAD_OP_ECC_READ 8'h19
`define SFAD_OP_PROT_FIRST 8'hFA
`define SFAD_OP_PROT_LAST 8'hFD
`define SFAD_OP_ID_READ 8'h9F
`define SFAD_OP_PARAM_TABLE 8'h5A
`define SFAD_OP_STATUS_ONE 8'h05
`define SFAD_OP_STATUS_TWO 8'h07
`define SFAD_OP_CONFIG_ONE 8'h35
`define SFAD_OP_STATUS_CONFIG_WR 8'h01
`define SFAD_OP_WRITE_DISABLE 8'h04
`define SFAD_OP_WRITE_ENABLE 8'h06
`define SFAD_OP_STATUS_CLEAR 8'h30
`define SFAD_OP_STATUS_CLEAR_ALT 8'h82
`define SFAD_OP_ENTER_WIDE 8'hB7
`define SFAD_ALEN_BIT 3'h7
`define SFAD_INSTR_LAST 6'h07
`define SFAD_A3_LAST 6'h17
`define SFAD_A4_LAST 6'h1F
`define SFAD_BITS_OP 6'h08
`define SFAD_BITS_OP_A3 6'h20
`define SFAD_BITS_OP_A4 6'h28
`define SFAD_MCLK_MHZ 200
`define SFAD_SLOW_MAX_MHZ 50
`define SFAD_FAST_MAX_MHZ 133
`define SFAD_HALF_DIV 2
`endif

// File: core/sfad_pkg.sv
/*
  Types, state records and the shared opcode decode for both link ends.
  Assumes sfad_defs.svh is on the include path.
*/
package sfad_pkg;
  `include "sfad_defs.svh"

  typedef enum logic [1:0] {AK_NONE, AK_THREE, AK_FOUR, AK_LEGACY} sfad_ak_t;

  typedef enum logic [4:0] {
    CL_NONE, CL_READ, CL_PROGRAM, CL_ERASE, CL_REG, CL_EES, CL_OTP, CL_ECC,
    CL_PROT, CL_ID, CL_PARAM, CL_STATUS1, CL_STATUS2, CL_CONFIG1, CL_WRR,
    CL_WRITE_DISABLE_CMD, CL_WRITE_ENABLE_CMD, CL_CLEAR, CL_RESUME, CL_ENTER4B
  } sfad_cls_t;

  typedef struct packed {
    logic known;
    sfad_ak_t ak;
    sfad_cls_t cls;
  } sfad_cmd_t;

  typedef enum logic [1:0] {PH_INSTR = 2'h0, PH_ADDR = 2'h1, PH_DONE = 2'h3} sfad_ph_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0, HS_SEL = 2'h1, HS_SHIFT = 2'h3, HS_DESEL = 2'h2
  } sfad_hst_t;

  typedef struct packed {
    sfad_ph_t ph;
    logic [5:0] cnt;
    logic [5:0] last;
    logic [31:0] sh;
    logic [7:0] op;
    sfad_cls_t cls;
    logic a4;
  } sfad_frame_t;

  typedef struct packed {
    logic nv_s1, nv_s2, qd_s1, qd_s2, rs_s1, rs_s2, sw_s1, sw_s2, sw_seen;
    logic load;
    logic [7:0] cfg2;
    logic ev_tog;
    logic [7:0] h_op;
    sfad_cls_t h_cls;
    logic [31:0] h_addr;
    logic h_a4;
  } sfad_link_t;

  typedef struct packed {
    logic sw_tog, ev_s1, ev_s2, ev_s3, al_s1, al_s2, valid;
    logic [7:0] op;
    sfad_cls_t cls;
    logic [31:0] addr;
    logic a4;
  } sfad_sys_t;

  typedef struct packed {
    sfad_hst_t st;
    logic [7:0] div;
    logic sck, cs_n;
    logic [5:0] left;
    logic [39:0] sh;
    logic a4, load, nv_s1, nv_s2, qd_s1, qd_s2, rs_s1, rs_s2, done;
  } sfad_host_t;

  // Reload of the address-length bit is pending from reset onward
  localparam sfad_link_t LINK_RST = '{load: 1'b1, h_cls: CL_NONE, default: '0};
  localparam sfad_host_t HOST_RST = '{st: HS_IDLE, cs_n: 1'b1, load: 1'b1, default: '0};

  function automatic sfad_cmd_t sfad_decode(input logic [7:0] op, input logic quad,
                                            input logic resume30);
    sfad_cmd_t c;
    c = '{known: 1'b1, ak: AK_NONE, cls: CL_NONE};
    unique case (op)
      `SFAD_OP_WIDE_READ, `SFAD_OP_WIDE_FAST_READ, `SFAD_OP_WIDE_DUAL_IO,
      `SFAD_OP_WIDE_QUAD_IO, `SFAD_OP_WIDE_DDR_QUAD: c = '{1'b1, AK_FOUR, CL_READ};
      `SFAD_OP_WIDE_PROGRAM: c = '{1'b1, AK_FOUR, CL_PROGRAM};
      `SFAD_OP_WIDE_PARAM_ERASE, `SFAD_OP_WIDE_SECTOR_ERASE: c = '{1'b1, AK_FOUR, CL_ERASE};
      `SFAD_OP_WIDE_ECC_READ: c = '{1'b1, AK_FOUR, CL_ECC};
      `SFAD_OP_READ, `SFAD_OP_FAST_READ, `SFAD_OP_DUAL_IO, `SFAD_OP_QUAD_IO,
      `SFAD_OP_DDR_QUAD: c = '{1'b1, AK_LEGACY, CL_READ};
      `SFAD_OP_PROGRAM: c = '{1'b1, AK_LEGACY, CL_PROGRAM};
      `SFAD_OP_PARAM_ERASE, `SFAD_OP_SECTOR_ERASE: c = '{1'b1, AK_LEGACY, CL_ERASE};
      `SFAD_OP_ANY_REG_READ, `SFAD_OP_ANY_REG_WRITE: c = '{1'b1, AK_LEGACY, CL_REG};
      `SFAD_OP_ERASE_EVAL: c = '{1'b1, AK_LEGACY, CL_EES};
      `SFAD_OP_OTP_PROGRAM, `SFAD_OP_OTP_READ: c = '{1'b1, AK_LEGACY, CL_OTP};
      `SFAD_OP_ECC_READ: c = '{1'b1, AK_LEGACY, CL_ECC};
      `SFAD_OP_ID_READ: c.cls = CL_ID;
      `SFAD_OP_PARAM_TABLE: c = '{1'b1, AK_THREE, CL_PARAM};
      `SFAD_OP_STATUS_ONE: c.cls = CL_STATUS1;
      `SFAD_OP_STATUS_TWO: c = '{!quad, AK_NONE, CL_STATUS2};
      `SFAD_OP_CONFIG_ONE: c = '{!quad, AK_NONE, CL_CONFIG1};
      `SFAD_OP_STATUS_CONFIG_WR: c.cls = CL_WRR;
      `SFAD_OP_WRITE_DISABLE: c.cls = CL_WRITE_DISABLE_CMD;
      `SFAD_OP_WRITE_ENABLE: c.cls = CL_WRITE_ENABLE_CMD;
      `SFAD_OP_STATUS_CLEAR: c.cls = resume30 ? CL_RESUME : CL_CLEAR;
      `SFAD_OP_STATUS_CLEAR_ALT: c.cls = CL_CLEAR;
      `SFAD_OP_ENTER_WIDE: c = '{!quad, AK_NONE, CL_ENTER4B};
      default: begin
        if (op >= `SFAD_OP_WIDE_PROT_FIRST && op <= `SFAD_OP_WIDE_PROT_LAST) begin
          c = '{1'b1, AK_FOUR, CL_PROT};
        end else if (op >= `SFAD_OP_PROT_FIRST && op <= `SFAD_OP_PROT_LAST) begin
          c = '{1'b1, AK_LEGACY, CL_PROT};
        end else begin
          c.known = 1'b0;
        end
      end
    endcase
    if (!c.known) begin
      c.cls = CL_NONE;
    end
    return c;
  endfunction
endpackage

// File: core/sfad_link_if.sv
/*
  Serial link between the host controller end and the flash device end.
  Assumes single-bit transfers, clock idle low, data sampled on rising edge.
*/
interface sfad_link_if;
  logic sck;
  logic cs_n;
  logic si;
  modport host_end (output sck, output cs_n, output si);
  modport dev_end (input sck, input cs_n, input si);
endinterface

// File: core/sfad_host_end.sv
/*
  Host controller end: sends one instruction and its address per request not refused quad-wide,
  making the link clock by dividing MCLK.
  Assumes the straps match those given to the device end.
*/
`include "sfad_defs.svh"

module sfad_host_end #(
  parameter int HALF_DIV = `SFAD_HALF_DIV
) (
  // System clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Link
  sfad_link_if.host_end LINK,
  // Configuration straps and controls
  input wire logic NV_ADDR_LEN,
  input wire logic QUAD_MODE,
  input wire logic RESUME_ON_30,
  input wire logic SW_RESET,
  // Request
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic [31:0] ADDR,
  // Answer
  output logic BUSY,
  output logic DONE,
  output logic ADDR_LEN_4B
);
  // One rate serves every opcode, so it must suit the slowest of them
  if (HALF_DIV < (`SFAD_MCLK_MHZ + 2 * `SFAD_SLOW_MAX_MHZ - 1) / (2 * `SFAD_SLOW_MAX_MHZ)
      || HALF_DIV > 255) begin : g_bad_div
    $error("HALF_DIV out of range");
  end

  sfad_pkg::sfad_host_t h_r;
  sfad_pkg::sfad_host_t h_nxt;

  always_comb begin
    sfad_pkg::sfad_cmd_t dq;
    sfad_pkg::sfad_cmd_t dn;
    logic tick;
    logic w4;
    dq = sfad_pkg::sfad_decode(OPCODE, h_r.qd_s2, h_r.rs_s2);
    dn = sfad_pkg::sfad_decode(OPCODE, 1'b0, h_r.rs_s2);
    tick = (h_r.div == 8'(HALF_DIV - 1));
    w4 = 1'b0;
    h_nxt = h_r;
    h_nxt.nv_s1 = NV_ADDR_LEN;
    h_nxt.nv_s2 = h_r.nv_s1;
    h_nxt.qd_s1 = QUAD_MODE;
    h_nxt.qd_s2 = h_r.qd_s1;
    h_nxt.rs_s1 = RESUME_ON_30;
    h_nxt.rs_s2 = h_r.rs_s1;
    h_nxt.done = 1'b0;
    h_nxt.div = tick ? 8'h00 : h_r.div + 8'h01;
    if (h_r.load) begin
      h_nxt.a4 = h_r.nv_s2;
    end
    unique case (h_r.st)
      sfad_pkg::HS_IDLE: begin
        h_nxt.div = 8'h00;
        // Quad-wide refusals are dropped here, never put on the link
        if (START && !(h_r.qd_s2 && dn.known && !dq.known)) begin
          h_nxt.load = 1'b0;
          w4 = (dq.ak == sfad_pkg::AK_FOUR) ||
               ((dq.ak == sfad_pkg::AK_LEGACY) && h_nxt.a4);
          if (!dq.known || dq.ak == sfad_pkg::AK_NONE) begin
            h_nxt.left = `SFAD_BITS_OP;
            h_nxt.sh = {OPCODE, 32'h0000_0000};
          end else if (w4) begin
            h_nxt.left = `SFAD_BITS_OP_A4;
            h_nxt.sh = {OPCODE, ADDR};
          end else begin
            h_nxt.left = `SFAD_BITS_OP_A3;
            h_nxt.sh = {OPCODE, ADDR[23:0], 8'h00};
          end
          if (dq.cls == sfad_pkg::CL_ENTER4B) begin
            h_nxt.a4 = 1'b1;
          end
          h_nxt.cs_n = 1'b0;
          h_nxt.st = sfad_pkg::HS_SEL;
        end
      end
      sfad_pkg::HS_SEL: begin
        if (tick) begin
          h_nxt.st = sfad_pkg::HS_SHIFT;
        end
      end
      sfad_pkg::HS_SHIFT: begin
        if (tick) begin
          h_nxt.sck = ~h_r.sck;
          if (h_r.sck) begin
            h_nxt.left = h_r.left - 6'h01;
            h_nxt.sh = {h_r.sh[38:0], 1'b0};
            if (h_r.left == 6'h01) begin
              h_nxt.cs_n = 1'b1;
              h_nxt.st = sfad_pkg::HS_DESEL;
            end
          end
        end
      end
      sfad_pkg::HS_DESEL: begin
        if (tick) begin
          h_nxt.done = 1'b1;
          h_nxt.st = sfad_pkg::HS_IDLE;
        end
      end
    endcase
    // Set wins over the clear taken by a request in the same cycle
    if (SW_RESET) begin
      h_nxt.load = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      h_r <= sfad_pkg::HOST_RST;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign LINK.sck = h_r.sck;
  assign LINK.cs_n = h_r.cs_n;
  assign LINK.si = h_r.sh[39];
  assign BUSY = (h_r.st != sfad_pkg::HS_IDLE);
  assign DONE = h_r.done;
  assign ADDR_LEN_4B = h_r.a4;
endmodule // sfad_host_end

// File: tb/sfad_link_monitor.sv
/*
  Checker for the serial link between the two ends and the host handshake.
  Assumes it is instantiated beside sfad_link_if in the bench, with no bind.
*/
module sfad_link_monitor (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  // Host and device user side
  input wire logic START,
  input wire logic QUAD_MODE,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic CMD_VALID
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sck_r;
  logic [5:0] rises_r;

  // Rising link clock edges seen in the current frame
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_r <= 1'h0;
      rises_r <= 6'h00;
    end else begin
      sck_r <= sck;
      if (cs_n) begin
        rises_r <= 6'h00;
      end else if (sck && !sck_r) begin
        rises_r <= rises_r + 6'h01;
      end
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_frame_bit_count: assert property ($rose(cs_n) |->
    rises_r == 6'h08 || rises_r == 6'h20 || rises_r == 6'h28)
    else $error("frame length not 8, 32 or 40 bits");
  a_data_stable_high: assert property (sck && $past(sck) |-> $stable(si))
    else $error("serial data moved while link clock high");
  a_idle_clock_low: assert property (cs_n |-> !sck)
    else $error("link clock high while deselected");
  a_cs_within_busy: assert property (!BUSY |-> cs_n)
    else $error("chip select low outside a request");
  a_start_opens_frame: assert property (START && !BUSY && !QUAD_MODE |=> BUSY ##1 !cs_n)
    else $error("accepted request did not open a frame");
  a_done_after_frame: assert property ($rose(cs_n) |-> ##[1:4] DONE)
    else $error("no completion after frame end");
  a_busy_ends_done: assert property ($fell(BUSY) |-> DONE)
    else $error("busy fell without completion");
  a_valid_in_frame: assert property (CMD_VALID |-> !$past(cs_n, 4))
    else $error("command reported without a frame");
  a_valid_one_cycle: assert property (CMD_VALID |=> !CMD_VALID)
    else $error("command pulse longer than one cycle");

  cover property ($rose(cs_n) && rises_r == 6'h08);
  cover property ($rose(cs_n) && rises_r == 6'h20);
  cover property ($rose(cs_n) && rises_r == 6'h28);
endmodule // sfad_link_monitor

// File: tb/spi_flash_addr_mode_cmd_decoder_tb.sv
/*
  Self-checking bench: host end and device end joined by one link; a
  behavioural decode model is compared with every reported command.
  Assumes the core package, interface and both ends compile first.
*/
module spi_flash_addr_mode_cmd_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_n, nv, quad, res30, sw_rst, start, busy, done, cmd_valid, cmd_addr4;
  logic dev_alen, host_alen;
  logic [7:0] opcode, cmd_opcode;
  logic [31:0] addr, cmd_addr;
  sfad_pkg::sfad_cls_t cmd_class;
  logic [45:0] seen_q[$];
  int miscompares, checked, alen;
  logic [7:0] ops [44] = '{8'h13, 8'h0C, 8'hBC, 8'hEC, 8'hEE, 8'h12, 8'h21, 8'hDC, 8'h18,
    8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hED, 8'h02, 8'h20, 8'hD8,
    8'h65, 8'h71, 8'hD0, 8'h42, 8'h4B, 8'h19, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'h9F, 8'h5A,
    8'h05, 8'h07, 8'h35, 8'h01, 8'h04, 8'h06, 8'h30, 8'h82, 8'h00, 8'hFF, 8'hC5};

  sfad_link_if link();
  sfad_host_end sfad_host_end_i (.MCLK(mclk), .RST_N(rst_n), .LINK(link), .NV_ADDR_LEN(nv),
    .QUAD_MODE(quad), .RESUME_ON_30(res30), .SW_RESET(sw_rst), .START(start),
    .OPCODE(opcode), .ADDR(addr), .BUSY(busy), .DONE(done), .ADDR_LEN_4B(host_alen));
  sfad_dev_end sfad_dev_end_i (.MCLK(mclk), .RST_N(rst_n), .LINK(link), .NV_ADDR_LEN(nv),
    .QUAD_MODE(quad), .RESUME_ON_30(res30), .SW_RESET(sw_rst), .CMD_VALID(cmd_valid),
    .CMD_OPCODE(cmd_opcode), .CMD_CLASS(cmd_class), .CMD_ADDR(cmd_addr),
    .CMD_ADDR4(cmd_addr4), .ADDR_LEN_4B(dev_alen));
  sfad_link_monitor sfad_link_monitor_i (.MCLK(mclk), .RST_N(rst_n), .sck(link.sck),
    .cs_n(link.cs_n), .si(link.si), .START(start), .QUAD_MODE(quad), .BUSY(busy),
    .DONE(done), .CMD_VALID(cmd_valid));

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (cmd_valid === 1'h1) seen_q.push_back({cmd_class, cmd_addr4, cmd_opcode, cmd_addr});
  end

  // Address kind: -1 unknown, 0 none, 3 fixed three, 4 fixed four, 5 follows the bit
  function automatic int model(input logic [7:0] op, output sfad_pkg::sfad_cls_t c);
    case (op)
      8'h13, 8'h0C, 8'hBC, 8'hEC, 8'hEE, 8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hED: c = sfad_pkg::CL_READ;
      8'h12, 8'h02: c = sfad_pkg::CL_PROGRAM;
      8'h21, 8'hDC, 8'h20, 8'hD8: c = sfad_pkg::CL_ERASE;
      8'h18, 8'h19: c = sfad_pkg::CL_ECC;
      8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hFA, 8'hFB, 8'hFC, 8'hFD: c = sfad_pkg::CL_PROT;
      8'h65, 8'h71: c = sfad_pkg::CL_REG;
      8'hD0: c = sfad_pkg::CL_EES;
      8'h42, 8'h4B: c = sfad_pkg::CL_OTP;
      8'h9F: c = sfad_pkg::CL_ID;
      8'h5A: c = sfad_pkg::CL_PARAM;
      8'h05: c = sfad_pkg::CL_STATUS1;
      8'h07: c = sfad_pkg::CL_STATUS2;
      8'h35: c = sfad_pkg::CL_CONFIG1;
      8'h01: c = sfad_pkg::CL_WRR;
      8'h04: c = sfad_pkg::CL_WRITE_DISABLE_CMD;
      8'h06: c = sfad_pkg::CL_WRITE_ENABLE_CMD;
      8'h30: c = res30 ? sfad_pkg::CL_RESUME : sfad_pkg::CL_CLEAR;
      8'h82: c = sfad_pkg::CL_CLEAR;
      8'hB7: c = sfad_pkg::CL_ENTER4B;
      default: c = sfad_pkg::CL_NONE;
    endcase
    case (op)
      8'h13, 8'h0C, 8'hBC, 8'hEC, 8'hEE, 8'h12, 8'h21, 8'hDC, 8'h18, 8'hE0, 8'hE1, 8'hE2,
        8'hE3: return 4;
      8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hED, 8'h02, 8'h20, 8'hD8, 8'h65, 8'h71, 8'hD0, 8'h42,
        8'h4B, 8'h19, 8'hFA, 8'hFB, 8'hFC, 8'hFD: return 5;
      8'h5A: return 3;
      default: return (c == sfad_pkg::CL_NONE) ? -1 : 0;
    endcase
  endfunction

  task automatic check(input string name, input logic [45:0] seen, input logic [45:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic hw_reset;
    rst_n = 1'h0;
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'h1;
    alen = nv;
    repeat (6) @(posedge mclk);
  endtask

  task automatic run(input logic [7:0] op);
    sfad_pkg::sfad_cls_t c;
    int k;
    logic a4, seen, refused;
    logic [31:0] a, ea;
    a = $urandom;
    k = model(op, c);
    refused = quad && (op == 8'h07 || op == 8'h35 || op == 8'hB7);
    a4 = (k == 4) || (k == 5 && alen == 1);
    ea = (k == 0) ? 32'h0 : a4 ? a : {8'h00, a[23:0]};
    seen = 1'h0;
    seen_q.delete();
    @(posedge mclk);
    #1;
    start = 1'h1;
    opcode = op;
    addr = a;
    @(posedge mclk);
    #1;
    start = 1'h0;
    for (int i = 0; i < 400 && !seen; i++) begin
      @(posedge mclk);
      #1;
      seen = (done === 1'h1);
    end
    repeat (8) @(posedge mclk);
    #1;
    check("done", 46'(seen), 46'(!refused));
    if (!seen && !refused) print_verdict();
    if (k >= 0 && !refused) begin
      check("count", 46'(seen_q.size()), 46'h1);
      if (seen_q.size() == 1) check("command", seen_q[0], {c, a4, op, ea});
    end else begin
      check("count", 46'(seen_q.size()), 46'h0);
    end
    if (op == 8'hB7 && !refused) alen = 1;
    if (!refused) begin
      check("dev alen", 46'(dev_alen), 46'(alen));
      check("host alen", 46'(host_alen), 46'(alen));
    end
  endtask

  initial begin
    rst_n = 1'h0;
    nv = 1'h0;
    quad = 1'h0;
    res30 = 1'h0;
    sw_rst = 1'h0;
    start = 1'h0;
    opcode = 8'h00;
    addr = 32'h0;
    miscompares = 0;
    checked = 0;
    void'($urandom(49544));
    hw_reset();
    // First pass at three bytes, then B7 switches legacy opcodes to four
    for (int p = 0; p < 2; p++) begin
      foreach (ops[i]) run(ops[i]);
      run(8'hB7);
    end
    // Software reset takes the bit back to the strap
    @(posedge mclk);
    #1;
    sw_rst = 1'h1;
    @(posedge mclk);
    #1;
    sw_rst = 1'h0;
    alen = nv;
    run(8'h05);
    run(8'h03);
    run(8'h13);
    nv = 1'h1;
    hw_reset();
    run(8'h05);
    run(8'h02);
    run(8'h5A);
    res30 = 1'h1;
    run(8'h30);
    quad = 1'h1;
    repeat (4) @(posedge mclk);
    run(8'h07);
    run(8'h35);
    run(8'hB7);
    run(8'h05);
    run(8'h30);
    print_verdict();
  end
endmodule // spi_flash_addr_mode_cmd_decoder_tb
